// *** hdl/ldo_thermal_irq_regs.sv ***
// Regulator fault and die temperature interrupt status, mask and sense
// Assumes the register port shares SYS_CLK_I; fault and comparator levels may be asynchronous
`timescale 1ns/1ps
`include "ldo_thermal_irq_consts.svh"
`default_nettype none
module ldo_thermal_irq_regs #(
	parameter int REG_COUNT = 3
) (
	// Clock, reset, enable
	input  wire logic                 SYS_CLK_I,
	input  wire logic                 RESETN_I,
	input  wire logic                 CLK_EN_I,
	// Register port
	input  wire logic [7:0]           REG_ADDR_I,
	input  wire logic                 REG_WR_I,
	input  wire logic [7:0]           REG_WDATA_I,
	input  wire logic                 REG_RD_I,
	output logic [7:0]                REG_RDATA_O,
	output logic                      REG_RVALID_O,
	// Analog comparator levels
	input  wire logic [REG_COUNT-1:0] FAULT_LEVEL_I,
	input  wire logic                 HOT_LOW_LEVEL_I,
	input  wire logic                 HOT_HIGH_LEVEL_I,
	// Interrupt pin
	output logic                      IRQ_OUT_N_O
);

	localparam int IN_W = REG_COUNT + 2;

	logic [IN_W-1:0]                  raw_in;
	logic [IN_W-1:0]                  sync_a;
	logic [IN_W-1:0]                  sync_b;
	logic [IN_W-1:0]                  level;
	logic [IN_W-1:0]                  next_level;
	logic [REG_COUNT-1:0]             reg_stat;
	logic [REG_COUNT-1:0]             next_reg_stat;
	logic [REG_COUNT-1:0]             reg_mask;
	logic [REG_COUNT-1:0]             next_reg_mask;
	logic [1:0]                       th_stat;
	logic [1:0]                       next_th_stat;
	logic [1:0]                       th_mask;
	logic [1:0]                       next_th_mask;
	logic [REG_COUNT-1:0]             rise_evt;
	logic [1:0]                       cross_evt;
	logic [REG_COUNT-1:0]             reg_clr;
	logic [1:0]                       th_clr;
	logic                             pending;
	logic                             next_irq_n;
	ldo_thermal_irq_pkg::reg_byte_type next_rdata;
	ldo_thermal_irq_pkg::reg_byte_type wide_reg_stat;
	ldo_thermal_irq_pkg::reg_byte_type wide_reg_mask;
	ldo_thermal_irq_pkg::reg_byte_type wide_reg_level;
	ldo_thermal_irq_pkg::reg_sel_type  sel;

	assign raw_in = {HOT_HIGH_LEVEL_I, HOT_LOW_LEVEL_I, FAULT_LEVEL_I};

	// Two-stage synchronisers, one per input
	genvar g;
	generate
		for (g = 0; g < IN_W; g++) begin : g_sync
			always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
				if (!RESETN_I) begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
				end else if (CLK_EN_I) begin
					sync_a[g] <= raw_in[g];
					sync_b[g] <= sync_a[g];
				end
			end
		end
	endgenerate

	// Address decode
	always_comb begin
		case (REG_ADDR_I)
			`LTI_ADDR_REG_STAT:  sel = ldo_thermal_irq_pkg::SEL_REG_STAT;
			`LTI_ADDR_REG_MASK:  sel = ldo_thermal_irq_pkg::SEL_REG_MASK;
			`LTI_ADDR_REG_SENSE: sel = ldo_thermal_irq_pkg::SEL_REG_SENSE;
			`LTI_ADDR_TH_STAT:   sel = ldo_thermal_irq_pkg::SEL_TH_STAT;
			`LTI_ADDR_TH_MASK:   sel = ldo_thermal_irq_pkg::SEL_TH_MASK;
			`LTI_ADDR_TH_SENSE:  sel = ldo_thermal_irq_pkg::SEL_TH_SENSE;
			default:             sel = ldo_thermal_irq_pkg::SEL_NONE;
		endcase
	end

	// Next register values
	always_comb begin
		wide_reg_stat  = '0;
		wide_reg_mask  = '0;
		wide_reg_level = '0;
		wide_reg_stat[REG_COUNT-1:0]  = reg_stat;
		wide_reg_mask[REG_COUNT-1:0]  = reg_mask;
		wide_reg_level[REG_COUNT-1:0] = level[REG_COUNT-1:0];

		next_level = sync_b;
		rise_evt   = sync_b[REG_COUNT-1:0] & ~level[REG_COUNT-1:0];
		cross_evt  = sync_b[IN_W-1:REG_COUNT] ^ level[IN_W-1:REG_COUNT];

		reg_clr = '0;
		th_clr  = '0;
		if (REG_RD_I && sel == ldo_thermal_irq_pkg::SEL_REG_STAT) begin
			reg_clr = '1;
		end else if (REG_WR_I && sel == ldo_thermal_irq_pkg::SEL_REG_STAT) begin
			reg_clr = REG_WDATA_I[REG_COUNT-1:0];
		end
		if (REG_RD_I && sel == ldo_thermal_irq_pkg::SEL_TH_STAT) begin
			th_clr = '1;
		end else if (REG_WR_I && sel == ldo_thermal_irq_pkg::SEL_TH_STAT) begin
			th_clr = {REG_WDATA_I[`LTI_BIT_HOT_HIGH], REG_WDATA_I[`LTI_BIT_HOT_LOW]};
		end

		// Sticky, and a new event wins over a clear
		next_reg_stat = (reg_stat & ~reg_clr) | rise_evt;
		next_th_stat  = (th_stat & ~th_clr) | cross_evt;

		next_reg_mask = reg_mask;
		next_th_mask  = th_mask;
		if (REG_WR_I && sel == ldo_thermal_irq_pkg::SEL_REG_MASK) begin
			next_reg_mask = REG_WDATA_I[REG_COUNT-1:0];
		end
		if (REG_WR_I && sel == ldo_thermal_irq_pkg::SEL_TH_MASK) begin
			next_th_mask = {REG_WDATA_I[`LTI_BIT_HOT_HIGH], REG_WDATA_I[`LTI_BIT_HOT_LOW]};
		end

		next_rdata = REG_RDATA_O;
		if (REG_RD_I) begin
			next_rdata = '0;
			case (sel)
				ldo_thermal_irq_pkg::SEL_REG_STAT:  next_rdata = wide_reg_stat;
				ldo_thermal_irq_pkg::SEL_REG_MASK:  next_rdata = wide_reg_mask;
				ldo_thermal_irq_pkg::SEL_REG_SENSE: next_rdata = wide_reg_level;
				ldo_thermal_irq_pkg::SEL_TH_STAT: begin
					next_rdata[`LTI_BIT_HOT_LOW]  = th_stat[0];
					next_rdata[`LTI_BIT_HOT_HIGH] = th_stat[1];
				end
				ldo_thermal_irq_pkg::SEL_TH_MASK: begin
					next_rdata[`LTI_BIT_HOT_LOW]  = th_mask[0];
					next_rdata[`LTI_BIT_HOT_HIGH] = th_mask[1];
				end
				ldo_thermal_irq_pkg::SEL_TH_SENSE: begin
					next_rdata[`LTI_BIT_HOT_LOW]  = level[REG_COUNT];
					next_rdata[`LTI_BIT_HOT_HIGH] = level[REG_COUNT+1];
				end
				default: next_rdata = '0;
			endcase
		end

		// Interrupt pin pulled low by any unmasked status bit
		pending    = (|(reg_stat & ~reg_mask)) | (|(th_stat & ~th_mask));
		next_irq_n = ~pending;
	end

	// Register stage
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			level        <= '0;
			reg_stat     <= `LTI_STAT_RESET;
			th_stat      <= `LTI_TH_STAT_RESET;
			reg_mask     <= `LTI_REG_MASK_RESET;
			th_mask      <= `LTI_TH_MASK_RESET;
			REG_RDATA_O  <= `LTI_RDATA_RESET;
			REG_RVALID_O <= 1'b0;
			IRQ_OUT_N_O  <= 1'b1;
		end else if (CLK_EN_I) begin
			level        <= next_level;
			reg_stat     <= next_reg_stat;
			th_stat      <= next_th_stat;
			reg_mask     <= next_reg_mask;
			th_mask      <= next_th_mask;
			REG_RDATA_O  <= next_rdata;
			REG_RVALID_O <= REG_RD_I;
			IRQ_OUT_N_O  <= next_irq_n;
		end
	end

	// Checks
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);

	sequence s_fault_rise;
		CLK_EN_I && $rose(FAULT_LEVEL_I[0]) ##1 (CLK_EN_I && FAULT_LEVEL_I[0]) [*2];
	endsequence

	sequence s_clear_on_rise;
		CLK_EN_I && rise_evt[0] && REG_WR_I && sel == ldo_thermal_irq_pkg::SEL_REG_STAT && REG_WDATA_I[0];
	endsequence

	a_irq_unmasked_low: assert property (CLK_EN_I && pending |=> !IRQ_OUT_N_O)
		else $error("unmasked status did not pull interrupt low");
	a_irq_masked_high: assert property (CLK_EN_I && !pending |=> IRQ_OUT_N_O)
		else $error("interrupt low with no unmasked status");
	a_mask_reset_val: assert property ($rose(RESETN_I) |-> reg_mask == `LTI_REG_MASK_RESET && th_mask == `LTI_TH_MASK_RESET)
		else $error("mask reset value wrong");
	a_fault_sense_sync: assert property (s_fault_rise |=> level[0] ##1 level[0])
		else $error("fault sense did not follow synchronised input");
	a_low_cross_set: assert property (CLK_EN_I && cross_evt[0] |=> th_stat[0])
		else $error("lower threshold crossing not latched");
	a_high_cross_set: assert property (CLK_EN_I && cross_evt[1] |=> th_stat[1])
		else $error("upper threshold crossing not latched");
	a_read_clears: assert property (CLK_EN_I && REG_RD_I && sel == ldo_thermal_irq_pkg::SEL_TH_STAT && cross_evt == 2'h0
		|=> th_stat == 2'h0 && REG_RVALID_O)
		else $error("thermal status read did not clear");
	a_status_sticky: assert property (reg_stat[1] && !(REG_RD_I || REG_WR_I) |=> reg_stat[1])
		else $error("regulator status dropped without clear");
	a_thermal_sense: assert property (CLK_EN_I && $changed(sync_b[REG_COUNT+1]) |=> level[REG_COUNT+1] == $past(sync_b[REG_COUNT+1]))
		else $error("upper thermal sense did not follow");
	a_mask_write: assert property (CLK_EN_I && REG_WR_I && sel == ldo_thermal_irq_pkg::SEL_TH_MASK
		|=> th_mask == {$past(REG_WDATA_I[`LTI_BIT_HOT_HIGH]), $past(REG_WDATA_I[`LTI_BIT_HOT_LOW])})
		else $error("thermal mask write not stored");
	a_set_beats_clear: assert property (s_clear_on_rise |=> reg_stat[0] ##1 (!IRQ_OUT_N_O || $past(reg_mask[0]) || !$past(CLK_EN_I)))
		else $error("new event lost to same-cycle clear");
	a_rise_latches: assert property (CLK_EN_I && rise_evt[2] |=> reg_stat[2])
		else $error("regulator fault rise not latched");
	a_reg_mask_write: assert property (CLK_EN_I && REG_WR_I && sel == ldo_thermal_irq_pkg::SEL_REG_MASK
		|=> reg_mask == $past(REG_WDATA_I[REG_COUNT-1:0]))
		else $error("regulator mask write not stored");
	a_low_sense_read: assert property (CLK_EN_I && REG_RD_I && sel == ldo_thermal_irq_pkg::SEL_TH_SENSE
		|=> REG_RVALID_O && REG_RDATA_O[`LTI_BIT_HOT_LOW] == $past(level[REG_COUNT]))
		else $error("lower thermal sense read wrong");

endmodule
`default_nettype wire

// *** shared/ldo_thermal_irq_consts.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes an 8-bit register port driven by the control interface slave
`ifndef LDO_THERMAL_IRQ_CONSTS_SVH
`define LDO_THERMAL_IRQ_CONSTS_SVH

// Register offsets
`define LTI_ADDR_REG_STAT   8'h18
`define LTI_ADDR_REG_MASK   8'h19
`define LTI_ADDR_REG_SENSE  8'h1a
`define LTI_ADDR_TH_STAT    8'h20
`define LTI_ADDR_TH_MASK    8'h21
`define LTI_ADDR_TH_SENSE   8'h22

// Thermal field positions within a register byte
`define LTI_BIT_HOT_LOW     0
`define LTI_BIT_HOT_HIGH    2

// Reset values
`define LTI_REG_MASK_RESET  3'h7
`define LTI_TH_MASK_RESET   2'h3
`define LTI_STAT_RESET      3'h0
`define LTI_TH_STAT_RESET   2'h0
`define LTI_RDATA_RESET     8'h00

// Timing: synchroniser stages ahead of the sense level flop
`define LTI_SYNC_STAGES     2

`endif

// *** shared/ldo_thermal_irq_pkg.sv ***
// Types for the regulator fault and thermal interrupt registers
// Assumes the offsets of ldo_thermal_irq_consts.svh
`default_nettype none
package ldo_thermal_irq_pkg;

	typedef logic [7:0] reg_byte_type;

	typedef enum logic [2:0] {
		SEL_NONE      = 3'b000,
		SEL_REG_STAT  = 3'b001,
		SEL_REG_MASK  = 3'b010,
		SEL_REG_SENSE = 3'b011,
		SEL_TH_STAT   = 3'b100,
		SEL_TH_MASK   = 3'b101,
		SEL_TH_SENSE  = 3'b110
	} reg_sel_type;

endpackage
`default_nettype wire

// *** tb/host_port.sv ***
// Host side of the register port: single-byte reads and writes
// Assumes the bench clock; signals change on its falling edge
`timescale 1ns/1ps
`default_nettype none
module host_port (
	// Clock
	input  wire logic       clk,
	// Register port
	output logic [7:0]      addr,
	output logic            wr,
	output logic [7:0]      wdata,
	output logic            rd,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid
);
	initial begin
		addr = 8'h00;
		wr = 1'b0;
		wdata = 8'h00;
		rd = 1'b0;
	end
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		wdata = ~d;
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		v = rvalid;
		d = rdata;
	endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the fault and thermal interrupt registers
// Assumes host_port as the register master
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
	logic       clk, rst_n, en, wr, rd, rvalid, irq_n, hot_lo, hot_hi, v;
	logic [7:0] addr, wdata, rdata, d, e, a;
	logic [2:0] fault;
	logic [7:0] m_r, m_t, s_r, s_t, lv_r, lv_t;
	logic [31:0] seed = 32'h58eb_0bfe;
	logic [31:0] r;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] adr [7] = '{8'h18, 8'h19, 8'h1a, 8'h20, 8'h21, 8'h22, 8'h30};
	logic [7:0] rst_v [7] = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
	ldo_thermal_irq_regs uut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(en),
		.REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd),
		.REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .FAULT_LEVEL_I(fault),
		.HOT_LOW_LEVEL_I(hot_lo), .HOT_HIGH_LEVEL_I(hot_hi), .IRQ_OUT_N_O(irq_n));
	host_port host (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd),
		.rdata(rdata), .rvalid(rvalid));
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic [7:0] model_rd(input logic [7:0] x);
		case (x)
			8'h18: return s_r;
			8'h19: return m_r;
			8'h1a: return lv_r;
			8'h20: return s_t;
			8'h21: return m_t;
			8'h22: return lv_t;
			default: return 8'h00;
		endcase
	endfunction
	task drive_in(input logic [4:0] x);
		fault = x[2:0];
		hot_lo = x[3];
		hot_hi = x[4];
		s_r = s_r | ({5'h00, fault} & ~lv_r);
		s_t = s_t | ({5'h00, hot_hi, 1'b0, hot_lo} ^ lv_t);
		lv_r = {5'h00, fault};
		lv_t = {5'h00, hot_hi, 1'b0, hot_lo};
	endtask
	task rd_chk(input logic [7:0] x);
		host.read(x, d, v);
		`CHK("rvalid", 1'b1, v)
		`CHK("rdata", model_rd(x), d)
		if (x == 8'h18) s_r = 8'h00;
		if (x == 8'h20) s_t = 8'h00;
	endtask
	task report_and_stop();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		clk = 1'b0;
		en = 1'b1;
		rst_n = 1'b0;
		fault = 3'h0;
		hot_lo = 1'b0;
		hot_hi = 1'b0;
		m_r = 8'h07;
		m_t = 8'h05;
		s_r = 8'h00;
		s_t = 8'h00;
		lv_r = 8'h00;
		lv_t = 8'h00;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		`CHK("irq", 1'b1, irq_n)
		foreach (adr[i]) begin
			host.read(adr[i], d, v);
			`CHK("rvalid", 1'b1, v)
			`CHK("reset", rst_v[i], d)
		end
		for (int n = 0; n < 300; n++) begin
			r = xs();
			drive_in(r[4:0]);
			repeat (5) @(negedge clk);
			`CHK("irq", ~|((s_r & ~m_r) | (s_t & ~m_t)), irq_n)
			a = adr[r[7:5] % 7];
			if (r[8]) begin
				rd_chk(a);
			end else begin
				host.write(a, r[23:16]);
				if (a == 8'h18) s_r = s_r & ~r[23:16];
				if (a == 8'h20) s_t = s_t & ~r[23:16];
				if (a == 8'h19) m_r = r[23:16] & 8'h07;
				if (a == 8'h21) m_t = r[23:16] & 8'h05;
			end
			repeat (2) @(negedge clk);
			`CHK("irq", ~|((s_r & ~m_r) | (s_t & ~m_t)), irq_n)
		end
		// New event against a same-cycle clear
		drive_in(5'h00);
		repeat (5) @(negedge clk);
		rd_chk(8'h18);
		rd_chk(8'h20);
		host.write(8'h19, 8'h00);
		m_r = 8'h00;
		drive_in(5'h01);
		@(negedge clk);
		host.write(8'h18, 8'h01);
		repeat (2) @(negedge clk);
		`CHK("irq", ~|((s_r & ~m_r) | (s_t & ~m_t)), irq_n)
		rd_chk(8'h18);
		e = s_t;
		drive_in(5'h09);
		@(negedge clk);
		host.read(8'h20, d, v);
		`CHK("rdata", e, d)
		rd_chk(8'h20);
		// Clock enable low freezes everything
		@(negedge clk);
		en = 1'b0;
		e[0] = ~|((s_r & ~m_r) | (s_t & ~m_t));
		drive_in(5'h1f);
		repeat (6) @(negedge clk);
		`CHK("irq", e[0], irq_n)
		host.write(8'h19, 8'h07);
		host.read(8'h19, d, v);
		`CHK("rvalid", 1'b0, v)
		en = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("irq", ~|((s_r & ~m_r) | (s_t & ~m_t)), irq_n)
		rd_chk(8'h18);
		rd_chk(8'h19);
		rd_chk(8'h20);
		// Reset in mid-run with all inputs high
		rst_n = 1'b0;
		m_r = 8'h07;
		m_t = 8'h05;
		s_r = 8'h00;
		s_t = 8'h00;
		lv_r = 8'h00;
		lv_t = 8'h00;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		`CHK("irq", 1'b1, irq_n)
		drive_in({hot_hi, hot_lo, fault});
		repeat (5) @(negedge clk);
		`CHK("irq", ~|((s_r & ~m_r) | (s_t & ~m_t)), irq_n)
		foreach (adr[i]) rd_chk(adr[i]);
		report_and_stop();
	end
endmodule
`default_nettype wire
